/* common/pclu_consts.svh */
// Purpose: constants for the program counter load unit
// Assumes: 8-bit register port, 15-bit program counter
// Notes:   offsets decode on their low seven bits in every bank
// Function
// - hold 15-bit pc; low byte readable, writable
// - upper pc bits reachable only via latch
// - any reset clears whole pc
// - low byte write loads latch into upper
// - low byte write yields latch plus byte
// - latch holds seven upper address bits
// - computed jump writes low byte, no carry
// - call: operand low eleven, latch bits 6:3
// - computed call: accumulator low, latch upper
// - accumulator branch: pc plus one plus unsigned
// - operand branch: pc plus one plus signed
// - branches use advanced pc, any block
// - core registers decode in every bank
// - push increments pointer, then stores pc
// - push and pop leave latch unchanged
`ifndef PCLU_CONSTS_SVH
`define PCLU_CONSTS_SVH

`define PCLU_PC_W          15
`define PCLU_LATCH_W       7
`define PCLU_SP_W          5
`define PCLU_DEPTH         16
`define PCLU_BANK_MASK     12'h07f
`define PCLU_OFF_PC_LOW    12'h002
`define PCLU_OFF_LATCH     12'hf8a
`define PCLU_OFF_SP        12'hfed
`define PCLU_OFF_TOS_LO    12'hfee
`define PCLU_OFF_TOS_HI    12'hfef
`define PCLU_RST_PC        15'h0000
`define PCLU_RST_LATCH     7'h00
`define PCLU_RST_SP        5'h1f
`define PCLU_INT_VECTOR    15'h0004

`endif

/* common/pclu_pkg.sv */
// Purpose: types shared by the program counter load unit
// Assumes: decoder presents at most one operation per cycle
// Notes:   zero code means no pc-changing operation
package pclu_pkg;
    typedef enum logic [5:0] {
        PCLU_OP_NONE  = 6'h00,
        PCLU_OP_CALL  = 6'h01,
        PCLU_OP_CCALL = 6'h02,
        PCLU_OP_ABR   = 6'h04,
        PCLU_OP_OBR   = 6'h08,
        PCLU_OP_RET   = 6'h10,
        PCLU_OP_INTV  = 6'h20
    } pclu_op_t;
endpackage : pclu_pkg

/* design/pclu_stack.sv */
// Purpose: return address stack with software access to pointer and top
// Assumes: push and pop never in the same cycle
// Notes:   wraps circularly; no overflow reset here
`timescale 1ns/1ps
`include "pclu_consts.svh"
module pclu_stack
    import pclu_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   push,
    input  wire logic                   pop,
    input  wire logic [`PCLU_PC_W-1:0]  push_data,
    input  wire logic                   sp_wr,
    input  wire logic                   tos_lo_wr,
    input  wire logic                   tos_hi_wr,
    input  wire logic [7:0]             wdata,
    output logic      [`PCLU_SP_W-1:0]  sp,
    output logic      [`PCLU_PC_W-1:0]  tos
);
    typedef struct packed {
        logic [`PCLU_SP_W-1:0] sp;
    } pclu_stk_st_t;

    pclu_stk_st_t st_reg;
    pclu_stk_st_t st_next;
    logic [`PCLU_PC_W-1:0] mem [`PCLU_DEPTH];
    logic [`PCLU_SP_W-1:0] sp_inc;

    assign sp_inc = st_reg.sp + 5'h01;
    assign sp     = st_reg.sp;
    assign tos    = mem[st_reg.sp[3:0]];

    always_comb begin
        st_next = st_reg;
        if (push)
            st_next.sp = sp_inc;
        else if (pop)
            st_next.sp = st_reg.sp - 5'h01;
        else if (sp_wr)
            st_next.sp = wdata[`PCLU_SP_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            st_reg <= '{sp: `PCLU_RST_SP};
        else
            st_reg <= st_next;
    end

    // storage needs no reset; contents are undefined until pushed
    always_ff @(posedge ref_clk) begin
        if (push)
            mem[sp_inc[3:0]] <= push_data;
        else if (tos_lo_wr)
            mem[st_reg.sp[3:0]][7:0] <= wdata;
        else if (tos_hi_wr)
            mem[st_reg.sp[3:0]][14:8] <= wdata[6:0];
    end

    property p_push_order;
        @(posedge ref_clk) disable iff (!rstn)
        push |=> (st_reg.sp == $past(st_reg.sp) + 5'h01)
                 && (tos == $past(push_data));
    endproperty
    a_push_order: assert property (p_push_order)
        else $error("push did not advance pointer then store");
endmodule : pclu_stack

/* design/pclu_top.sv */
// Purpose: program counter sequencing and its core registers
// Assumes: register port and decoder run on ref_clk
// Notes:   decoder operation wins over a same-cycle low byte write
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "pclu_consts.svh"
module pclu_top
    import pclu_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic [11:0]            reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire pclu_op_t               op_kind,
    input  wire logic [10:0]            op_operand,
    input  wire logic [7:0]             acc_value,
    input  wire logic                   fetch,
    output logic      [`PCLU_PC_W-1:0]  pc_out,
    output logic                        push_out
);
    typedef struct packed {
        logic [`PCLU_PC_W-1:0]    pc;
        logic [`PCLU_LATCH_W-1:0] latch;
        logic [7:0]               rdata;
        logic                     push;
    } pclu_st_t;

    pclu_st_t st_reg;
    pclu_st_t st_next;

    // bank bits are ignored so every bank reaches the same register
    function automatic logic addr_hit(input logic [11:0] a,
                                      input logic [11:0] off);
        addr_hit = ((a & `PCLU_BANK_MASK) == (off & `PCLU_BANK_MASK));
    endfunction : addr_hit

    logic                  hit_pc_lo;
    logic                  hit_latch;
    logic                  hit_sp;
    logic                  hit_tlo;
    logic                  hit_thi;
    logic [`PCLU_PC_W-1:0] pc_inc;
    logic [`PCLU_PC_W-1:0] opr_off;
    logic [`PCLU_PC_W-1:0] acc_off;
    logic                  stk_push;
    logic                  stk_pop;
    logic [`PCLU_PC_W-1:0] stk_push_data;
    logic [`PCLU_SP_W-1:0] stk_sp;
    logic [`PCLU_PC_W-1:0] stk_tos;

    assign hit_pc_lo = addr_hit(reg_addr, `PCLU_OFF_PC_LOW);
    assign hit_latch = addr_hit(reg_addr, `PCLU_OFF_LATCH);
    assign hit_sp    = addr_hit(reg_addr, `PCLU_OFF_SP);
    assign hit_tlo   = addr_hit(reg_addr, `PCLU_OFF_TOS_LO);
    assign hit_thi   = addr_hit(reg_addr, `PCLU_OFF_TOS_HI);

    // branch base is the already advanced pc; sum carries freely
    assign pc_inc  = st_reg.pc + 15'h0001;
    assign acc_off = {7'h00, acc_value};
    assign opr_off = {{6{op_operand[8]}}, op_operand[8:0]};

    // calls save the next instruction; a vectored interrupt saves
    // the instruction it preempted, which has not yet executed
    assign stk_push = (op_kind == PCLU_OP_CALL)
                   || (op_kind == PCLU_OP_CCALL)
                   || (op_kind == PCLU_OP_INTV);
    assign stk_pop  = (op_kind == PCLU_OP_RET);
    assign stk_push_data = (op_kind == PCLU_OP_INTV) ? st_reg.pc : pc_inc;

    pclu_stack u_stack (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .push      (stk_push),
        .pop       (stk_pop),
        .push_data (stk_push_data),
        .sp_wr     (reg_wr && hit_sp),
        .tos_lo_wr (reg_wr && hit_tlo),
        .tos_hi_wr (reg_wr && hit_thi),
        .wdata     (reg_wdata),
        .sp        (stk_sp),
        .tos       (stk_tos)
    );

    always_comb begin
        st_next = st_reg;
        st_next.push = stk_push;

        // only a software write touches the latch, never the stack
        if (reg_wr && hit_latch)
            st_next.latch = reg_wdata[`PCLU_LATCH_W-1:0];

        case (op_kind)
            PCLU_OP_CALL:
                st_next.pc = {st_reg.latch[6:3], op_operand};
            PCLU_OP_CCALL:
                st_next.pc = {st_reg.latch, acc_value};
            PCLU_OP_ABR:
                st_next.pc = pc_inc + acc_off;
            PCLU_OP_OBR:
                st_next.pc = pc_inc + opr_off;
            PCLU_OP_RET:
                st_next.pc = stk_tos;
            PCLU_OP_INTV:
                st_next.pc = `PCLU_INT_VECTOR;
            default: begin
                // computed goto is a plain low byte write: the upper
                // bits come from the latch, so no carry crosses 256
                if (reg_wr && hit_pc_lo)
                    st_next.pc = {st_reg.latch, reg_wdata};
                else if (fetch)
                    st_next.pc = pc_inc;
            end
        endcase

        st_next.rdata = 8'h00;
        if (reg_rd) begin
            if (hit_pc_lo)
                st_next.rdata = st_reg.pc[7:0];
            else if (hit_latch)
                st_next.rdata = {1'b0, st_reg.latch};
            else if (hit_sp)
                st_next.rdata = {3'b000, stk_sp};
            else if (hit_tlo)
                st_next.rdata = stk_tos[7:0];
            else if (hit_thi)
                st_next.rdata = {1'b0, stk_tos[14:8]};
            // upper pc bits have no read path of their own
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            st_reg <= '{pc: `PCLU_RST_PC, latch: `PCLU_RST_LATCH,
                        rdata: 8'h00, push: 1'b0};
        else
            st_reg <= st_next;
    end

    assign pc_out    = st_reg.pc;
    assign reg_rdata = st_reg.rdata;
    assign push_out  = st_reg.push;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic idle_op;
    assign idle_op = (op_kind == PCLU_OP_NONE);

    property p_reset_clear;
        @(posedge ref_clk) disable iff (1'b0)
        !rstn |-> (pc_out == `PCLU_RST_PC);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("pc not cleared under reset");

    property p_low_read;
        reg_rd && hit_pc_lo |=> reg_rdata == $past(st_reg.pc[7:0]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low byte read returned wrong value");

    property p_latch_no_pc;
        reg_wr && hit_latch && idle_op && !fetch |=> $stable(pc_out);
    endproperty
    a_latch_no_pc: assert property (p_latch_no_pc)
        else $error("latch write moved the pc directly");

    property p_low_write_upper;
        reg_wr && hit_pc_lo && idle_op
            |=> pc_out[14:8] == $past(st_reg.latch);
    endproperty
    a_low_write_upper: assert property (p_low_write_upper)
        else $error("low byte write did not load latch upper");

    sequence s_low_write;
        reg_wr && hit_pc_lo && idle_op;
    endsequence

    property p_low_write_full;
        s_low_write |=> pc_out == {$past(st_reg.latch), $past(reg_wdata)};
    endproperty
    a_low_write_full: assert property (p_low_write_full)
        else $error("full pc after low byte write wrong");

    property p_latch_store;
        reg_wr && hit_latch ##1 reg_rd && hit_latch && !reg_wr
            |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)};
    endproperty
    a_latch_store: assert property (p_latch_store)
        else $error("latch did not keep seven written bits");

    property p_no_carry;
        s_low_write ##0 st_reg.pc[7:0] == 8'hff && reg_wdata == 8'h00
            |=> pc_out[14:8] == $past(st_reg.latch);
    endproperty
    a_no_carry: assert property (p_no_carry)
        else $error("computed jump carried into upper bits");

    property p_call;
        op_kind == PCLU_OP_CALL |=> pc_out ==
            {$past(st_reg.latch[6:3]), $past(op_operand)};
    endproperty
    a_call: assert property (p_call)
        else $error("call target wrong");

    property p_ccall;
        op_kind == PCLU_OP_CCALL
            |=> pc_out == {$past(st_reg.latch), $past(acc_value)};
    endproperty
    a_ccall: assert property (p_ccall)
        else $error("computed call target wrong");

    property p_abr;
        op_kind == PCLU_OP_ABR |=> pc_out ==
            15'($past(st_reg.pc) + 15'h0001 + {7'h00, $past(acc_value)});
    endproperty
    a_abr: assert property (p_abr)
        else $error("accumulator branch target wrong");

    property p_obr;
        op_kind == PCLU_OP_OBR |=> pc_out ==
            15'($past(st_reg.pc) + 15'h0001
                + {{6{$past(op_operand[8])}}, $past(op_operand[8:0])});
    endproperty
    a_obr: assert property (p_obr)
        else $error("operand branch target wrong");

    // read data must return to zero so a stale byte is never mistaken
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");

    property p_no_upper_read;
        reg_rd && !(hit_pc_lo || hit_latch || hit_sp || hit_tlo || hit_thi)
            |=> reg_rdata == 8'h00;
    endproperty
    a_no_upper_read: assert property (p_no_upper_read)
        else $error("unmapped read returned data");

    property p_pc_hold;
        idle_op && !fetch && !(reg_wr && hit_pc_lo) |=> $stable(pc_out);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc moved without a load case");

    property p_push_ptr;
        stk_push |=> stk_sp == $past(stk_sp) + 5'h01;
    endproperty
    a_push_ptr: assert property (p_push_ptr)
        else $error("push did not advance the stack pointer");

    property p_call_ret_addr;
        op_kind == PCLU_OP_CALL || op_kind == PCLU_OP_CCALL
            |=> stk_tos == 15'($past(st_reg.pc) + 15'h0001);
    endproperty
    a_call_ret_addr: assert property (p_call_ret_addr)
        else $error("call saved wrong return address");

    property p_intv_save;
        op_kind == PCLU_OP_INTV
            |=> stk_tos == $past(st_reg.pc) && pc_out == `PCLU_INT_VECTOR;
    endproperty
    a_intv_save: assert property (p_intv_save)
        else $error("interrupt vectoring saved or jumped wrong");

    property p_bank_low;
        reg_rd && (reg_addr[6:0] == 7'h02)
            |=> reg_rdata == $past(st_reg.pc[7:0]);
    endproperty
    a_bank_low: assert property (p_bank_low)
        else $error("pc low byte not visible in this bank");

    property p_any_bank;
        reg_rd && (reg_addr[6:0] == 7'h0a)
            |=> reg_rdata == {1'b0, $past(st_reg.latch)};
    endproperty
    a_any_bank: assert property (p_any_bank)
        else $error("latch not visible in this bank");

    property p_push_flag;
        stk_push |=> push_out ##1 !push_out || $past(stk_push);
    endproperty
    a_push_flag: assert property (p_push_flag)
        else $error("push indication not one cycle");

    property p_latch_kept;
        (stk_push || stk_pop) && !(reg_wr && hit_latch)
            |=> $stable(st_reg.latch);
    endproperty
    a_latch_kept: assert property (p_latch_kept)
        else $error("stack action changed the latch");

    property p_advance;
        fetch && idle_op && !(reg_wr && hit_pc_lo)
            |=> pc_out == 15'($past(st_reg.pc) + 15'h0001);
    endproperty
    a_advance: assert property (p_advance)
        else $error("pc did not advance by one");

    c_wrap: cover property (fetch && idle_op && st_reg.pc == 15'h7fff);
    c_call_ret: cover property (op_kind == PCLU_OP_CALL ##[1:20]
                                op_kind == PCLU_OP_RET);
    c_goto: cover property (reg_wr && hit_latch ##[1:4] s_low_write);
    c_obr_back: cover property (op_kind == PCLU_OP_OBR
                                && op_operand[8]);
endmodule : pclu_top

/* test/pclu_tb.sv */
// Purpose: self-checking bench for the program counter load unit
// Assumes: one decoder op per cycle, results one edge after the request
// Notes:   cyc() holds the reference model; a monitor pops its notes
`timescale 1ns/1ps
`include "pclu_consts.svh"
module tb
    import pclu_pkg::*;
;
    logic        ref_clk, rstn, reg_wr, reg_rd, fetch, push_out, rd_q, act_q;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, acc_value;
    logic [10:0] op_operand;
    logic [14:0] pc_out, pc_m;
    logic [14:0] stk_m [16];
    logic [6:0]  latch_m;
    logic [4:0]  sp_m;
    pclu_op_t    op_kind;
    pclu_op_t    ops [5] = '{PCLU_OP_CALL, PCLU_OP_CCALL, PCLU_OP_ABR,
                             PCLU_OP_OBR, PCLU_OP_INTV};
    logic [7:0]  rq [$];
    logic [15:0] pq [$];
    logic [7:0]  rd_exp;
    logic [15:0] pc_exp;
    int          fail_count, compares, depth;

    pclu_top DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .op_kind(op_kind), .op_operand(op_operand),
        .acc_value(acc_value), .fetch(fetch), .pc_out(pc_out),
        .push_out(push_out));

    always #5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    function automatic logic [7:0] rd_model(input logic [11:0] a);
        case (a[6:0])
            7'h02:   return pc_m[7:0];
            7'h0a:   return {1'b0, latch_m};
            7'h6d:   return {3'b000, sp_m};
            7'h6e:   return stk_m[sp_m[3:0]][7:0];
            7'h6f:   return {1'b0, stk_m[sp_m[3:0]][14:8]};
            default: return 8'h00;
        endcase
    endfunction : rd_model

    // one bus/decoder cycle; every input is assigned exactly once per edge
    task automatic cyc(input logic w, input logic r, input logic [11:0] a,
                       input logic [7:0] d, input pclu_op_t o,
                       input logic [10:0] n, input logic [7:0] acc,
                       input logic f);
        logic [14:0] nx;
        logic [14:0] pv;
        logic        pu;
        reg_wr <= w; reg_rd <= r; reg_addr <= a; reg_wdata <= d;
        op_kind <= o; op_operand <= n; acc_value <= acc; fetch <= f;
        if (r) rq.push_back(rd_model(a));
        nx = pc_m;
        pv = pc_m + 15'd1;
        pu = 1'b0;
        case (o)
            PCLU_OP_CALL:  begin nx = {latch_m[6:3], n}; pu = 1'b1; end
            PCLU_OP_CCALL: begin nx = {latch_m, acc}; pu = 1'b1; end
            PCLU_OP_ABR:   nx = pc_m + 15'd1 + {7'd0, acc};
            PCLU_OP_OBR:   nx = pc_m + 15'd1 + {{6{n[8]}}, n[8:0]};
            PCLU_OP_RET:   begin nx = stk_m[sp_m[3:0]]; sp_m--; depth--; end
            PCLU_OP_INTV:  begin nx = `PCLU_INT_VECTOR; pu = 1'b1; pv = pc_m; end
            default: begin
                if (w && a[6:0] == 7'h02) nx = {latch_m, d};
                else if (f) nx = pc_m + 15'd1;
            end
        endcase
        if (pu) begin
            sp_m++;
            stk_m[sp_m[3:0]] = pv;
            depth++;
        end
        if (w) begin
            case (a[6:0])
                7'h0a: latch_m = d[6:0];
                7'h6d: sp_m = d[4:0];
                7'h6e: stk_m[sp_m[3:0]][7:0] = d;
                7'h6f: stk_m[sp_m[3:0]][14:8] = d[6:0];
                default: ;
            endcase
        end
        if (o != PCLU_OP_NONE || f || (w && a[6:0] == 7'h02))
            pq.push_back({pu, nx});
        pc_m = nx;
        @(posedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d, PCLU_OP_NONE, 11'h000, 8'h00, 1'b0);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        cyc(1'b0, 1'b1, a, 8'h00, PCLU_OP_NONE, 11'h000, 8'h00, 1'b0);
    endtask : rd
    task automatic op(input pclu_op_t o, input logic [10:0] n,
                      input logic [7:0] acc);
        cyc(1'b0, 1'b0, 12'h000, 8'h00, o, n, acc, 1'b0);
    endtask : op

    always @(posedge ref_clk) begin
        rd_q  <= reg_rd & rstn;
        act_q <= rstn & (fetch | (op_kind != PCLU_OP_NONE)
                 | (reg_wr & (reg_addr[6:0] == 7'h02)));
    end

    // outputs are judged mid-cycle, long after the edge has settled
    always @(negedge ref_clk) begin
        if (rd_q && rq.size() > 0) begin
            rd_exp = rq.pop_front();
            check("reg_rdata", {8'h00, reg_rdata}, {8'h00, rd_exp});
        end else if (rstn) begin
            check("reg_rdata idle", {8'h00, reg_rdata}, 16'h0000);
        end
        if (act_q && pq.size() > 0) begin
            pc_exp = pq.pop_front();
            check("push_out,pc_out", {push_out, pc_out}, pc_exp);
        end else if (rstn) begin
            check("push_out idle", {15'h0000, push_out}, 16'h0000);
        end
    end

    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end

    initial begin
        ref_clk = 1'b0; rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 12'h000; reg_wdata = 8'h00; op_kind = PCLU_OP_NONE;
        op_operand = 11'h000; acc_value = 8'h00; fetch = 1'b0;
        rd_q = 1'b0; act_q = 1'b0; pc_m = 15'h0000; latch_m = 7'h00;
        sp_m = 5'h1f; depth = 0; fail_count = 0; compares = 0;
        void'($urandom(32'h4c3c));
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        for (int k = 0; k < 2; k++) begin
            rd(12'h002);
            rd(12'hf8a);
            rd(12'hfed);
            wr(12'h00a, 8'h12);
            wr(12'h002, 8'h34);
            rd(12'h002);
            wr(12'h08a, 8'hff);
            rd(12'hf8a);
            wr(12'h002, 8'hff);
            cyc(1'b0, 1'b0, 12'h000, 8'h00, PCLU_OP_NONE, 11'h0, 8'h0,
                1'b1);
            wr(12'h00c, 8'h55);
            rd(12'h00c);
            wr(12'h00a, 8'h01);
            // low byte wraps from ff to 00: the upper bits must not carry
            wr(12'h002, 8'hff);
            wr(12'h002, 8'h00);
            wr(12'h00a, 8'h0d);
            op(PCLU_OP_CALL, 11'h7ff, 8'h00);
            op(PCLU_OP_CCALL, 11'h000, 8'h9a);
            rd(12'hfed);
            rd(12'hfee);
            rd(12'hfef);
            rd(12'h00a);
            op(PCLU_OP_RET, 11'h000, 8'h00);
            op(PCLU_OP_RET, 11'h000, 8'h00);
            op(PCLU_OP_INTV, 11'h000, 8'h00);
            wr(12'h00a, 8'h00);
            wr(12'h002, 8'hf0);
            op(PCLU_OP_ABR, 11'h000, 8'h20);
            op(PCLU_OP_OBR, 11'h1e0, 8'h00);
            op(PCLU_OP_OBR, 11'h6ff, 8'h00);
            op(pclu_op_t'(6'h03), 11'h123, 8'h44);
            cyc(1'b1, 1'b0, 12'h002, 8'h55, PCLU_OP_ABR, 11'h0, 8'hff,
                1'b1);
            wr(12'hfed, 8'h03);
            wr(12'hfee, 8'h78);
            wr(12'hfef, 8'hd6);
            rd(12'hfef);
            op(PCLU_OP_RET, 11'h000, 8'h00);
            depth = 0;
            repeat (150) begin
                case ($urandom_range(0, 6))
                    0: wr({5'($urandom), 7'h0a}, 8'($urandom));
                    1: wr({5'($urandom), 7'h02}, 8'($urandom));
                    2: op(ops[$urandom_range(0, 4)], 11'($urandom),
                          8'($urandom));
                    3: if (depth > 0) op(PCLU_OP_RET, 11'h000, 8'h00);
                       else rd({5'($urandom), 7'h0c});
                    4: rd({5'($urandom), 7'h02});
                    5: if (depth > 0) rd({5'($urandom), 7'h6e});
                       else rd({5'($urandom), 7'h6d});
                    default: cyc(1'b0, 1'b0, 12'h000, 8'h00, PCLU_OP_NONE,
                                 11'h000, 8'h00, 1'b1);
                endcase
            end
            cyc(1'b0, 1'b0, 12'h000, 8'h00, PCLU_OP_NONE, 11'h0, 8'h0, 1'b0);
            // mid-run reset: the second pass repeats the directed steps from zero, with new random traffic
            rstn <= 1'b0;
            repeat (2) @(posedge ref_clk);
            pc_m = 15'h0000;
            latch_m = 7'h00;
            sp_m = 5'h1f;
            depth = 0;
            rstn <= 1'b1;
            @(posedge ref_clk);
        end
        end_of_test();
    end
endmodule : tb
